// >>> rtl/branch_control_instr_exec.sv
/*
 * Execution sequencer for compare/skip, increment/decrement/skip,
 * bit-test/skip, branch, call, return, context save/restore and no-op.
 * Assumes the fetch stage presents one decoded instruction with its
 * operand already read, and that all inputs are synchronous to sys_clk.
 */
`timescale 1ns/1ps

//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - compare with immediate sets zero/carry, skips when equal, 1+S cycles
// - compare with memory sets zero/carry, skips when equal, 1+S cycles
// - increment-skip puts operand+1 in accumulator, skips on zero
// - increment-memory-skip writes operand+1 back, skips on zero, 1+N+S
// - decrement-skip puts operand-1 in accumulator, skips on zero, 1+S
// - decrement-memory-skip writes operand-1 back, skips on zero, 1+N+S
// - bit test skips next instruction when selected bit is zero, 1+S
// - bit test skips next instruction when selected bit is one, 1+S
// - bank-zero bit tests read operand from bank 0 always
// - branch loads page bits and 14-bit target into counter, 2 cycles
// - call pushes program counter plus one, then loads target like branch
// - interrupt return pops counter and sets global enable; return pops
// - save copies accumulator and flags, not status bits, in one cycle
// - restore reloads accumulator and flags, status bits untouched
// - memory cost is zero for system registers, one for general RAM
// - skip cost is one when the skip condition holds, else zero
module branch_control_instr_exec #(
	parameter int STACK_DEPTH = branch_pkg::STACK_DEPTH
) (
	// clock and reset
	input  wire logic                                  sys_clk,
	input  wire logic                                  srst,
	// decoded instruction
	input  wire logic                                  instrValid,
	output logic                                       instrReady,
	input  branch_pkg::op_e                            instrOp,
	input  wire logic [branch_pkg::DATA_W-1:0]         instrImm,
	input  wire logic [branch_pkg::TARGET_W-1:0]       instrTarget,
	input  wire logic [branch_pkg::BIT_SEL_W-1:0]      instrBitSel,
	input  wire logic [branch_pkg::ADDR_W-1:0]         instrMemAddr,
	input  wire logic                                  instrMemIsSys,
	input  wire logic [branch_pkg::DATA_W-1:0]         operandData,
	output logic                                       operandBank0,
	// core state
	input  wire logic [branch_pkg::PAGE_W-1:0]         programPageSelect,
	input  wire logic                                  timeoutWakeupStatus,
	input  wire logic                                  powerdownStatus,
	input  wire logic                                  gieClear,
	input  wire logic                                  accWrEn,
	input  wire logic [branch_pkg::DATA_W-1:0]         accWrData,
	input  wire logic                                  flagWrEn,
	input  wire logic [branch_pkg::DATA_W-1:0]         flagWrData,
	output logic [branch_pkg::DATA_W-1:0]              accumulatorRegister,
	output logic [branch_pkg::DATA_W-1:0]              programFlagRegister,
	output logic [branch_pkg::PC_W-1:0]                programCounter,
	output logic                                       globalIntEnable,
	// data memory write
	output logic                                       memWrEn,
	output logic [branch_pkg::ADDR_W-1:0]              memWrAddr,
	output logic                                       memWrBank0,
	output logic [branch_pkg::DATA_W-1:0]              memWrData
);
	localparam int SP_W = $clog2(STACK_DEPTH);
	if (STACK_DEPTH < 2 || (1 << SP_W) != STACK_DEPTH) begin : g_bad_depth
		$error("STACK_DEPTH must be a power of two of at least 2");
	end
	typedef enum logic [1:0] {ST_RUN, ST_MEMWR, ST_SKIP, ST_BRANCH} state_e;
	state_e                            stateQ, stateD;
	logic [branch_pkg::DATA_W-1:0]     accQ, accD;
	logic [branch_pkg::DATA_W-1:0]     flagQ, flagD;
	logic [branch_pkg::DATA_W-1:0]     accShadowQ, flagShadowQ;
	logic [branch_pkg::PC_W-1:0]       pcQ, pcD;
	logic [branch_pkg::PC_W-1:0]       stackMem [STACK_DEPTH];
	logic [SP_W-1:0]                   spQ;
	logic                              gieQ;
	logic                              skipPendQ;
	logic                              memWrEnQ, memWrBank0Q;
	logic [branch_pkg::ADDR_W-1:0]     memWrAddrQ;
	logic [branch_pkg::DATA_W-1:0]     memWrDataQ;

	exec_if evalBus ();

	//////////////////////////////////////////////////////////////////////////
	// decode
	wire take     = instrValid && (stateQ == ST_RUN);
	wire discard  = instrValid && (stateQ == ST_SKIP);
	wire isCmp    = (instrOp == branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM) ||
		(instrOp == branch_pkg::OP_COMPARE_SKIP_EQUAL_MEM);
	wire isAccRes = (instrOp == branch_pkg::OP_INCREMENT_SKIP_ZERO) ||
		(instrOp == branch_pkg::OP_DECREMENT_SKIP_ZERO);
	wire isMemRes = (instrOp == branch_pkg::OP_INCREMENT_MEMORY_SKIP_ZERO) ||
		(instrOp == branch_pkg::OP_DECREMENT_MEMORY_SKIP_ZERO);
	wire isBank0  = (instrOp == branch_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR) ||
		(instrOp == branch_pkg::OP_BANK0_BIT_TEST_SKIP_SET);
	wire isJump   = (instrOp == branch_pkg::OP_ABSOLUTE_BRANCH) ||
		(instrOp == branch_pkg::OP_SUBROUTINE_CALL);
	wire isCall   = (instrOp == branch_pkg::OP_SUBROUTINE_CALL);
	wire isIntRet = (instrOp == branch_pkg::OP_INTERRUPT_RETURN);
	wire isRet    = (instrOp == branch_pkg::OP_SUBROUTINE_RETURN) || isIntRet;
	wire isSave   = (instrOp == branch_pkg::OP_CONTEXT_SAVE);
	wire isRest   = (instrOp == branch_pkg::OP_CONTEXT_RESTORE);

	// memory cost and skip cost of the instruction being taken
	wire ramCost  = isMemRes && !instrMemIsSys;
	wire skipCost = evalBus.skip;
	wire [SP_W-1:0]             spDec    = spQ - 1'b1;
	wire [branch_pkg::PC_W-1:0] pcNext   = pcQ + 16'h0001;
	wire [branch_pkg::PC_W-1:0] jumpDest = {programPageSelect, instrTarget};
	assign evalBus.op      = instrOp;
	assign evalBus.acc     = accQ;
	assign evalBus.operand = operandData;
	assign evalBus.imm     = instrImm;
	assign evalBus.bitSel  = instrBitSel;

	skip_cond_eval u_eval (
		.bus (evalBus.eval)
	);

	//////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb begin
		stateD = stateQ;
		case (stateQ)
			ST_RUN: begin
				if (take && (isJump || isRet))
					stateD = ST_BRANCH;
				else if (take && ramCost)
					stateD = ST_MEMWR;
				else if (take && skipCost)
					stateD = ST_SKIP;
			end
			ST_MEMWR: begin
				stateD = skipPendQ ? ST_SKIP : ST_RUN;
			end
			ST_SKIP: begin
				// the fetched word is consumed here and never executed
				if (instrValid)
					stateD = ST_RUN;
			end
			ST_BRANCH: begin
				stateD = ST_RUN;
			end
			default: begin
				stateD = ST_RUN;
			end
		endcase
	end

	assign instrReady   = (stateQ == ST_RUN) || (stateQ == ST_SKIP);
	assign operandBank0 = isBank0;

	//////////////////////////////////////////////////////////////////////////
	// datapath next values
	always_comb begin
		pcD = pcQ;
		if (take && isJump)
			pcD = jumpDest;
		else if (take && isRet)
			pcD = stackMem[spDec];
		else if (take || discard)
			pcD = pcNext;
	end

	always_comb begin
		accD = accQ;
		if (take && isAccRes)
			accD = evalBus.result;
		else if (take && isRest)
			accD = accShadowQ;
		else if (accWrEn && !take)
			accD = accWrData;
	end

	// status bits are never stored here; they come straight from the inputs
	always_comb begin
		flagD = flagQ;
		if (take && isCmp) begin
			flagD[branch_pkg::FLAG_ZERO]  = evalBus.zeroF;
			flagD[branch_pkg::FLAG_CARRY] = evalBus.carryF;
		end else if (take && isRest) begin
			flagD = flagShadowQ & branch_pkg::FLAG_SAVE_MASK;
		end else if (flagWrEn && !take) begin
			flagD = flagWrData & branch_pkg::FLAG_SAVE_MASK;
		end
	end

	//////////////////////////////////////////////////////////////////////////
	// registers
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			stateQ <= ST_RUN;
			pcQ    <= branch_pkg::PC_RST;
			accQ   <= branch_pkg::ACC_RST;
			flagQ  <= branch_pkg::FLAG_RST;
		end else begin
			stateQ <= stateD;
			pcQ    <= pcD;
			accQ   <= accD;
			flagQ  <= flagD;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			accShadowQ  <= branch_pkg::ACC_RST;
			flagShadowQ <= branch_pkg::FLAG_RST;
		end else if (take && isSave) begin
			accShadowQ  <= accQ;
			flagShadowQ <= flagQ & branch_pkg::FLAG_SAVE_MASK;
		end
	end

	// return address is the word after the call
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			spQ <= '0;
		end else if (take && isCall) begin
			stackMem[spQ] <= pcNext;
			spQ           <= spQ + 1'b1;
		end else if (take && isRet) begin
			spQ <= spDec;
		end
	end

	// a return-from-interrupt beats a simultaneous clear request
	always_ff @(posedge sys_clk) begin
		if (srst)
			gieQ <= branch_pkg::GIE_RST;
		else if (take && isIntRet)
			gieQ <= 1'b1;
		else if (gieClear)
			gieQ <= 1'b0;
	end

	// system register writes land one cycle later without stalling
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			memWrEnQ    <= 1'b0;
			memWrAddrQ  <= '0;
			memWrBank0Q <= 1'b0;
			memWrDataQ  <= '0;
			skipPendQ   <= 1'b0;
		end else begin
			memWrEnQ  <= take && isMemRes;
			skipPendQ <= take && skipCost;
			if (take && isMemRes) begin
				memWrAddrQ  <= instrMemAddr;
				memWrBank0Q <= 1'b0;
				memWrDataQ  <= evalBus.result;
			end
		end
	end

	assign accumulatorRegister = accQ;
	assign programCounter      = pcQ;
	assign globalIntEnable     = gieQ;
	assign memWrEn             = memWrEnQ;
	assign memWrAddr           = memWrAddrQ;
	assign memWrBank0          = memWrBank0Q;
	assign memWrData           = memWrDataQ;

	always_comb begin
		programFlagRegister = flagQ;
		programFlagRegister[branch_pkg::FLAG_TIMEOUT] = timeoutWakeupStatus;
		programFlagRegister[branch_pkg::FLAG_PWRDN]   = powerdownStatus;
	end

	//////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	sequence s_skip_slot;
		!instrReady || (stateQ == ST_SKIP);
	endsequence
	sequence s_one_bubble;
		!instrReady ##1 instrReady;
	endsequence

	a_cmp_equal_skip: assert property (take && isCmp && skipCost
		|=> (stateQ == ST_SKIP) && flagQ[branch_pkg::FLAG_ZERO])
		else $error("equal compare did not skip");
	a_cmp_carry_flag: assert property (take && isCmp
		|=> flagQ[branch_pkg::FLAG_CARRY] == ($past(instrOp) ==
		branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM ? $past(accQ) >= $past(instrImm)
		: $past(accQ) >= $past(operandData)))
		else $error("compare carry wrong");
	a_inc_acc_value: assert property (take &&
		instrOp == branch_pkg::OP_INCREMENT_SKIP_ZERO
		|=> accQ == $past(operandData) + 8'h01 && !memWrEn)
		else $error("increment result wrong");
	a_incmem_ram_cost: assert property (take && ramCost &&
		instrOp == branch_pkg::OP_INCREMENT_MEMORY_SKIP_ZERO
		|=> memWrEn && memWrData == $past(operandData) + 8'h01 ##0 s_one_bubble)
		else $error("ram increment timing wrong");
	a_dec_acc_value: assert property (take &&
		instrOp == branch_pkg::OP_DECREMENT_SKIP_ZERO
		|=> accQ == $past(operandData) - 8'h01)
		else $error("decrement result wrong");
	a_decmem_skip_after: assert property (take && ramCost && skipCost
		|=> stateQ == ST_MEMWR ##1 stateQ == ST_SKIP)
		else $error("memory skip order wrong");
	a_bit_clear_skip: assert property (take &&
		instrOp == branch_pkg::OP_BIT_TEST_SKIP_CLEAR &&
		!operandData[instrBitSel] |=> s_skip_slot)
		else $error("clear bit test missed skip");
	a_bit_set_skip: assert property (take &&
		instrOp == branch_pkg::OP_BIT_TEST_SKIP_SET &&
		operandData[instrBitSel] |=> stateQ == ST_SKIP)
		else $error("set bit test missed skip");
	a_branch_target: assert property (take && isJump
		|=> pcQ == {$past(programPageSelect), $past(instrTarget)}
		##0 s_one_bubble)
		else $error("branch target or timing wrong");
	a_call_push: assert property (take && isCall
		|=> spQ == $past(spQ) + 1'b1)
		else $error("call did not push");
	a_intret_enable: assert property (take && isIntRet
		|=> globalIntEnable ##0 s_one_bubble)
		else $error("interrupt return did not enable");
	a_restore_acc: assert property (take && isRest
		|=> accQ == $past(accShadowQ) && instrReady)
		else $error("restore wrong");
	a_sysreg_no_stall: assert property (take && isMemRes &&
		instrMemIsSys && !skipCost |=> instrReady && memWrEn)
		else $error("system register write stalled");
	a_discard_effect: assert property (discard && !accWrEn
		|=> accQ == $past(accQ) && !memWrEn && pcQ == $past(pcQ) + 16'h0001)
		else $error("discarded instruction had effect");
	a_nop_only_pc: assert property (take &&
		instrOp == branch_pkg::OP_NOP && !accWrEn && !flagWrEn
		|=> accQ == $past(accQ) && flagQ == $past(flagQ) &&
		pcQ == $past(pcQ) + 16'h0001 && instrReady)
		else $error("no-op changed state");
endmodule : branch_control_instr_exec

// >>> rtl/branch_pkg.sv
/*
 * Shared constants and types for the branch and skip execution block:
 * widths, flag layout, reset values, cycle costs and the operation codes.
 * Assumes the fetch stage decodes instruction words into op_e codes.
 */
package branch_pkg;

	localparam int DATA_W      = 8;
	localparam int PC_W        = 16;
	localparam int TARGET_W    = 14;
	localparam int PAGE_W      = 2;
	localparam int BIT_SEL_W   = 3;
	localparam int ADDR_W      = 8;
	localparam int STACK_DEPTH = 8;

	// program flag register layout
	localparam int FLAG_CARRY   = 0;
	localparam int FLAG_DCARRY  = 1;
	localparam int FLAG_ZERO    = 2;
	localparam int FLAG_PWRDN   = 6;
	localparam int FLAG_TIMEOUT = 7;
	localparam logic [DATA_W-1:0] FLAG_SAVE_MASK = 8'h3f;

	// reset values
	localparam logic [DATA_W-1:0] ACC_RST  = 8'h00;
	localparam logic [DATA_W-1:0] FLAG_RST = 8'h00;
	localparam logic [PC_W-1:0]   PC_RST   = 16'h0000;
	localparam logic              GIE_RST  = 1'b0;

	// cycle costs
	localparam int CYC_BASE   = 1;
	localparam int CYC_BRANCH = 2;
	localparam int CYC_SYSREG = 0;
	localparam int CYC_RAM    = 1;
	localparam int CYC_SKIP   = 1;
	localparam int CYC_NOSKIP = 0;

	typedef enum logic [4:0] {
		OP_NOP,
		OP_COMPARE_SKIP_EQUAL_IMM,
		OP_COMPARE_SKIP_EQUAL_MEM,
		OP_INCREMENT_SKIP_ZERO,
		OP_INCREMENT_MEMORY_SKIP_ZERO,
		OP_DECREMENT_SKIP_ZERO,
		OP_DECREMENT_MEMORY_SKIP_ZERO,
		OP_BIT_TEST_SKIP_CLEAR,
		OP_BIT_TEST_SKIP_SET,
		OP_BANK0_BIT_TEST_SKIP_CLEAR,
		OP_BANK0_BIT_TEST_SKIP_SET,
		OP_ABSOLUTE_BRANCH,
		OP_SUBROUTINE_CALL,
		OP_SUBROUTINE_RETURN,
		OP_INTERRUPT_RETURN,
		OP_CONTEXT_SAVE,
		OP_CONTEXT_RESTORE,
		OP_OTHER
	} op_e;

endpackage : branch_pkg

// >>> rtl/exec_if.sv
/*
 * Carrier between the sequencer and the condition evaluator.
 * Assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
interface exec_if;
	branch_pkg::op_e                         op;
	logic [branch_pkg::DATA_W-1:0]           acc;
	logic [branch_pkg::DATA_W-1:0]           operand;
	logic [branch_pkg::DATA_W-1:0]           imm;
	logic [branch_pkg::BIT_SEL_W-1:0]        bitSel;
	logic [branch_pkg::DATA_W-1:0]           result;
	logic                                    skip;
	logic                                    zeroF;
	logic                                    carryF;

	modport ctrl (output op, acc, operand, imm, bitSel,
		input result, skip, zeroF, carryF);
	modport eval (input op, acc, operand, imm, bitSel,
		output result, skip, zeroF, carryF);
endinterface : exec_if

// >>> rtl/skip_cond_eval.sv
/*
 * Condition evaluator: computes compare flags, increment and decrement
 * results and the skip decision for one operation.
 * Assumes operand and accumulator are stable for the whole cycle.
 */
`timescale 1ns/1ps
module skip_cond_eval (
	// evaluation channel
	exec_if.eval bus
);
	logic [branch_pkg::DATA_W:0]   diff;
	logic [branch_pkg::DATA_W-1:0] cmpVal;
	logic                          bitVal;

	assign cmpVal = (bus.op == branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM) ?
		bus.imm : bus.operand;
	assign diff   = {1'b0, bus.acc} - {1'b0, cmpVal};
	assign bitVal = bus.operand[bus.bitSel];

	always_comb begin
		bus.result = bus.operand;
		bus.skip   = 1'b0;
		bus.zeroF  = (diff[branch_pkg::DATA_W-1:0] == 8'h00);
		// carry set means no borrow
		bus.carryF = ~diff[branch_pkg::DATA_W];
		case (bus.op)
			branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM,
			branch_pkg::OP_COMPARE_SKIP_EQUAL_MEM: begin
				bus.skip = (bus.acc == cmpVal);
			end
			branch_pkg::OP_INCREMENT_SKIP_ZERO,
			branch_pkg::OP_INCREMENT_MEMORY_SKIP_ZERO: begin
				bus.result = bus.operand + 8'h01;
				bus.skip   = (bus.operand == 8'hff);
			end
			branch_pkg::OP_DECREMENT_SKIP_ZERO,
			branch_pkg::OP_DECREMENT_MEMORY_SKIP_ZERO: begin
				bus.result = bus.operand - 8'h01;
				bus.skip   = (bus.operand == 8'h01);
			end
			branch_pkg::OP_BIT_TEST_SKIP_CLEAR,
			branch_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR: begin
				bus.skip = ~bitVal;
			end
			branch_pkg::OP_BIT_TEST_SKIP_SET,
			branch_pkg::OP_BANK0_BIT_TEST_SKIP_SET: begin
				bus.skip = bitVal;
			end
			default: begin
				bus.skip = 1'b0;
			end
		endcase
	end
endmodule : skip_cond_eval

// >>> sim/data_mem_model.sv
/*
 * Data memory on the far side of the branch block: two banks, read
 * without delay, write-back taken on the rising clock edge.
 * Assumes the bench preloads every cell it reads; others read unknown.
 */
`timescale 1ns/1ps
module data_mem_model #(
	parameter logic BANK_SEL = 1'b1
) (
	// clock
	input  wire logic       sys_clk,
	// operand read
	input  wire logic [7:0] rdAddr,
	input  wire logic       rdBank0,
	output logic      [7:0] rdData,
	// write back
	input  wire logic       wrEn,
	input  wire logic [7:0] wrAddr,
	input  wire logic       wrBank0,
	input  wire logic [7:0] wrData
);
	logic [7:0] mem [2][256];
	wire        rdBank = rdBank0 ? 1'b0 : BANK_SEL;
	wire        wrBank = wrBank0 ? 1'b0 : BANK_SEL;

	// bank-zero reads bypass the current bank selection
	assign rdData = mem[rdBank][rdAddr];

	always @(posedge sys_clk) begin
		if (wrEn)
			mem[wrBank][wrAddr] <= wrData;
	end
endmodule : data_mem_model

// >>> sim/branch_control_instr_exec_bench.sv
/*
 * Self-checking bench for the branch and skip execution block.
 * Assumes the data memory model answers operand reads at once.
 */
`timescale 1ns/1ps
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin n_mismatch++; \
	$display("Error at %0t: got %h expected %h", $time, a, e); end end
module branch_control_instr_exec_bench;
	logic sys_clk = 0, srst = 1, instrValid = 0, instrMemIsSys = 1;
	branch_pkg::op_e instrOp = branch_pkg::OP_NOP;
	logic [7:0]  instrImm = 0, instrMemAddr = 0, operandData;
	logic [13:0] instrTarget = 0;
	logic [2:0]  instrBitSel = 0;
	logic [1:0]  programPageSelect = 0;
	logic tw = 0, pd = 0, gieClear = 0, accWrEn = 0, flagWrEn = 0;
	logic [7:0]  accWrData = 0, flagWrData = 0, acc, flags, wrData, wrAddr;
	logic [15:0] pc, pcExp, ret1, ret2;
	logic instrReady, bank0, gie, wrEn, wrBank0, lastWr;
	logic [7:0]  lastWd, lastWa;
	int n_mismatch = 0, tests_run = 0, stall;

	branch_control_instr_exec branch_control_instr_exec_inst (
		.sys_clk(sys_clk), .srst(srst), .instrValid(instrValid),
		.instrReady(instrReady), .instrOp(instrOp), .instrImm(instrImm),
		.instrTarget(instrTarget), .instrBitSel(instrBitSel),
		.instrMemAddr(instrMemAddr), .instrMemIsSys(instrMemIsSys),
		.operandData(operandData), .operandBank0(bank0),
		.programPageSelect(programPageSelect), .timeoutWakeupStatus(tw),
		.powerdownStatus(pd), .gieClear(gieClear), .accWrEn(accWrEn),
		.accWrData(accWrData), .flagWrEn(flagWrEn),
		.flagWrData(flagWrData), .accumulatorRegister(acc),
		.programFlagRegister(flags), .programCounter(pc),
		.globalIntEnable(gie), .memWrEn(wrEn), .memWrAddr(wrAddr),
		.memWrBank0(wrBank0), .memWrData(wrData));
	data_mem_model data_mem_model_inst (
		.sys_clk(sys_clk), .rdAddr(instrMemAddr), .rdBank0(bank0),
		.rdData(operandData), .wrEn(wrEn), .wrAddr(wrAddr),
		.wrBank0(wrBank0), .wrData(wrData));

	initial begin
		forever #10 sys_clk = ~sys_clk;
	end

//////////////////////////////////////////////////////////////////////////////
	task automatic step;
		@(posedge sys_clk) #1;
	endtask : step

	task automatic poke(input logic b, input logic [7:0] a, v);
		data_mem_model_inst.mem[b][a] = v;
	endtask : poke

	task automatic setReg(input logic [7:0] a, f, input logic fw);
		step;
		accWrEn = 1;
		accWrData = a;
		flagWrEn = fw;
		flagWrData = f;
		step;
		accWrEn = 0;
		flagWrEn = 0;
	endtask : setReg

	// one idle cycle first so valid never toggles twice in a time step
	task automatic exec(input branch_pkg::op_e op, input logic [7:0] v,
		a, input logic [2:0] b, input logic sys);
		int g;
		step;
		instrOp = op;
		instrImm = v;
		instrMemAddr = a;
		instrBitSel = b;
		instrMemIsSys = sys;
		instrValid = 1;
		g = 0;
		while (instrReady !== 1'b1 && g < 20) @(posedge sys_clk) #1 g++;
		step;
		instrValid = 0;
		pcExp++;
		lastWr = wrEn;
		lastWd = wrData;
		lastWa = wrAddr;
		stall = 0;
		while (instrReady !== 1'b1 && stall < 10)
			@(posedge sys_clk) #1 stall++;
	endtask : exec

	// a write-back instruction; it leaves no write when discarded
	task automatic follow(input logic s);
		exec(branch_pkg::OP_INCREMENT_MEMORY_SKIP_ZERO, 0, 8'h20, 0, 1);
		`CHK(lastWr, !s)
		`CHK(pc, pcExp)
	endtask : follow

	// immediate and memory operand differ so the wrong source shows
	task automatic cmp(input branch_pkg::op_e op, input logic [7:0] a, v);
		logic imm;
		imm = (op == branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM);
		setReg(a, 0, 0);
		poke(1, 8'h10, imm ? ~v : v);
		exec(op, imm ? v : ~v, 8'h10, 0, 1);
		`CHK(flags[branch_pkg::FLAG_ZERO], a == v)
		`CHK(flags[branch_pkg::FLAG_CARRY], a >= v)
		`CHK(stall, 0)
		follow(a == v);
	endtask : cmp

	task automatic accOp(input logic inc, input logic [7:0] m);
		logic [7:0] r;
		r = inc ? m + 8'h01 : m - 8'h01;
		poke(1, 8'h30, m);
		exec(inc ? branch_pkg::OP_INCREMENT_SKIP_ZERO :
			branch_pkg::OP_DECREMENT_SKIP_ZERO, 0, 8'h30, 0, 1);
		`CHK(acc, r)
		`CHK(lastWr, 1'b0)
		follow(r == 8'h00);
		`CHK(data_mem_model_inst.mem[1][8'h30], m)
	endtask : accOp

	task automatic memOp(input logic inc, input logic [7:0] m,
		input logic sys);
		logic [7:0] r;
		r = inc ? m + 8'h01 : m - 8'h01;
		poke(1, 8'h40, m);
		exec(inc ? branch_pkg::OP_INCREMENT_MEMORY_SKIP_ZERO :
			branch_pkg::OP_DECREMENT_MEMORY_SKIP_ZERO, 0, 8'h40, 0, sys);
		`CHK({lastWr, lastWa, lastWd}, {1'b1, 8'h40, r})
		`CHK(wrBank0, 1'b0)
		`CHK(stall, sys ? 0 : 1)
		follow(r == 8'h00);
		`CHK(data_mem_model_inst.mem[1][8'h40], r)
	endtask : memOp

	task automatic bits;
		branch_pkg::op_e op;
		logic b0, bv;
		logic [7:0] pat;
		poke(0, 8'h50, 8'h5a);
		poke(1, 8'h50, 8'ha5);
		for (int k = 0; k < 4; k++) begin
			for (int i = 0; i < 8; i++) begin
				op = branch_pkg::op_e'(int'(branch_pkg::OP_BIT_TEST_SKIP_CLEAR) + k);
				b0 = k >= 2;
				pat = b0 ? 8'h5a : 8'ha5;
				bv = pat[i];
				exec(op, 0, 8'h50, i[2:0], 1);
				`CHK(bank0, b0)
				follow(k % 2 ? bv : !bv);
			end
		end
	endtask : bits

	task automatic branches;
		programPageSelect = 2'b10;
		instrTarget = 14'h1234;
		exec(branch_pkg::OP_ABSOLUTE_BRANCH, 0, 0, 0, 1);
		pcExp = 16'h9234;
		`CHK(pc, pcExp)
		`CHK(stall, 1)
		ret1 = pcExp + 16'h0001;
		instrTarget = 14'h0100;
		exec(branch_pkg::OP_SUBROUTINE_CALL, 0, 0, 0, 1);
		pcExp = 16'h8100;
		`CHK({pc, stall[1:0]}, {pcExp, 2'd1})
		ret2 = pcExp + 16'h0001;
		programPageSelect = 2'b01;
		instrTarget = 14'h3fff;
		exec(branch_pkg::OP_SUBROUTINE_CALL, 0, 0, 0, 1);
		pcExp = 16'h7fff;
		`CHK(pc, pcExp)
		exec(branch_pkg::OP_SUBROUTINE_RETURN, 0, 0, 0, 1);
		pcExp = ret2;
		`CHK({pc, gie, stall[1:0]}, {pcExp, 1'b0, 2'd1})
		exec(branch_pkg::OP_INTERRUPT_RETURN, 0, 0, 0, 1);
		pcExp = ret1;
		`CHK({pc, gie, stall[1:0]}, {pcExp, 1'b1, 2'd1})
		step;
		gieClear = 1;
		step;
		gieClear = 0;
		`CHK(gie, 1'b0)
	endtask : branches

	task automatic saveRestore;
		tw = 1;
		pd = 0;
		setReg(8'h3c, 8'h2d, 1);
		exec(branch_pkg::OP_CONTEXT_SAVE, 0, 0, 0, 1);
		`CHK(stall, 0)
		tw = 0;
		pd = 1;
		setReg(8'ha5, 8'h12, 1);
		exec(branch_pkg::OP_CONTEXT_RESTORE, 0, 0, 0, 1);
		`CHK({acc, flags}, {8'h3c, 2'b01, 6'h2d})
		`CHK(stall, 0)
		exec(branch_pkg::OP_NOP, 0, 8'h20, 0, 0);
		`CHK({acc, flags, pc, lastWr}, {8'h3c, 8'h6d, pcExp, 1'b0})
		`CHK(stall, 0)
	endtask : saveRestore

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run

//////////////////////////////////////////////////////////////////////////////
	initial begin
		#(20 * 4000);
		n_mismatch++;
		complete_run;
	end

	initial begin
		repeat (4) @(posedge sys_clk);
		#1;
		srst = 0;
		pcExp = 16'h0000;
		`CHK({pc, acc, flags, gie}, {16'h0000, 8'h00, 8'h00, 1'b0})
		poke(1, 8'h20, 8'h10);
		cmp(branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM, 8'h55, 8'h55);
		cmp(branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM, 8'h30, 8'h60);
		cmp(branch_pkg::OP_COMPARE_SKIP_EQUAL_IMM, 8'h60, 8'h30);
		cmp(branch_pkg::OP_COMPARE_SKIP_EQUAL_MEM, 8'h00, 8'h00);
		cmp(branch_pkg::OP_COMPARE_SKIP_EQUAL_MEM, 8'h7f, 8'h80);
		accOp(1, 8'hff);
		accOp(1, 8'h05);
		accOp(0, 8'h01);
		accOp(0, 8'h00);
		for (int s = 0; s < 2; s++) begin
			memOp(1, 8'hff, s[0]);
			memOp(1, 8'h41, s[0]);
			memOp(0, 8'h01, s[0]);
			memOp(0, 8'h00, s[0]);
		end
		bits;
		branches;
		saveRestore;
		complete_run;
	end
endmodule : branch_control_instr_exec_bench
